// ==== shared/dac_cfg_pkg.sv ====
/*
 Constants, field positions and small decoders shared by the serial audio
 port and its converter path. Assumes the register port and the audio
 path share one system clock, and the bit clock comes from the host.
*/
package dac_cfg_pkg;
	localparam logic [7:0] DAC_PATH_CONTROL_ADDR        = 8'h02;
	localparam logic [7:0] DIGITAL_VOLUME_ADDR          = 8'h03;
	localparam logic [7:0] SERIAL_PORT_CONTROL_ONE_ADDR = 8'h04;
	localparam logic [7:0] DAC_PATH_CONTROL_RESET        = 8'h32;
	localparam logic [7:0] DIGITAL_VOLUME_RESET          = 8'h40;
	localparam logic [7:0] SERIAL_PORT_CONTROL_ONE_RESET = 8'h11;
	localparam logic [7:0] UNMAPPED_READ                 = 8'h00;

	// dac_path_control fields
	localparam int unsigned HARD_VOLUME_BIT = 7;
	localparam int unsigned MUTE_BIT        = 6;
	localparam int unsigned HIGHPASS_BIT    = 5;
	localparam int unsigned LOW_POWER_BIT   = 4;
	localparam int unsigned RATE_LSB        = 0;
	// serial_port_control_one fields
	localparam int unsigned INVERT_BIT      = 7;
	localparam int unsigned EDGE_BIT        = 6;
	localparam int unsigned SLOT_LSB        = 3;
	localparam int unsigned STYLE_BIT       = 2;
	localparam int unsigned FORMAT_BIT      = 1;
	localparam int unsigned FRAMING_BIT     = 0;
	localparam int unsigned CODE3_W         = 3;

	// configuration word carried to the link side
	localparam int unsigned CFG_BITS        = 10;
	localparam int unsigned CFG_STYLE       = 0;
	localparam int unsigned CFG_FORMAT      = 1;
	localparam int unsigned CFG_FRAMING     = 2;
	localparam int unsigned CFG_SLOT_LSB    = 3;
	localparam int unsigned CFG_INDEX_LSB   = 6;
	localparam int unsigned INDEX_W         = 4;

	localparam logic [7:0] GAIN_UNITY       = 8'h40;
	localparam logic [7:0] GAIN_MUTE        = 8'hff;
	localparam logic [7:0] GAIN_STEP        = 8'h01;
	localparam int unsigned WORD_BITS       = 24;
	localparam int unsigned FRAC_BITS       = 15;
	localparam int unsigned HEADROOM_OCT    = 4;
	localparam int unsigned HPF_SHIFT       = 10;

	typedef enum logic [2:0] {
		RATE_8K   = 3'h0,
		RATE_16K  = 3'h1,
		RATE_32K  = 3'h2,
		RATE_64K  = 3'h3,
		RATE_128K = 3'h4,
		RATE_48K  = 3'h5
	} rate_range_t;

	typedef enum logic {
		FRAMING_STEREO = 1'b0,
		FRAMING_TDM    = 1'b1
	} framing_t;

	localparam logic [6:0] SLOT_CLOCKS_FALLBACK = 7'h20;

	function automatic logic [6:0] slot_clocks(input logic [2:0] code);
		case (code)
			3'h0: slot_clocks = 7'h10;
			3'h1: slot_clocks = 7'h18;
			3'h2: slot_clocks = 7'h20;
			3'h3: slot_clocks = 7'h30;
			3'h4: slot_clocks = 7'h40;
			default: slot_clocks = SLOT_CLOCKS_FALLBACK;
		endcase
	endfunction
endpackage

// ==== hdl/dac_serial_rx.sv ====
/*
 Link-side receiver: frames the serial audio stream on the bit clock and
 hands each word of this chip's slot across with a toggle.
 Assumes the configuration word changes only while the link is idle.
*/
`timescale 1ns/10ps
module dac_serial_rx #(
	parameter int unsigned WIDTH   = dac_cfg_pkg::WORD_BITS,
	parameter int unsigned COUNT_W = 11
) (
	input  wire logic                             i_clk_link,
	input  wire logic                             i_rst,
	input  wire logic                             i_frame_sync,
	input  wire logic                             i_serial_audio_in,
	input  wire logic [dac_cfg_pkg::CFG_BITS-1:0] i_cfg,
	output logic      [WIDTH-1:0]                 o_word,
	output logic                                  o_word_toggle
);
	import dac_cfg_pkg::*;

	if (WIDTH < 2 || COUNT_W < 11) begin : g_bad_size
		$error("dac_serial_rx: width or counter too small");
	end

	typedef struct packed {
		logic [CFG_BITS-1:0] cfg_s1;
		logic [CFG_BITS-1:0] cfg_s2;
		logic                fs_prev;
		logic [COUNT_W-1:0]  cnt;
		logic [WIDTH-1:0]    shift;
		logic [WIDTH-1:0]    word;
		logic                toggle;
	} rx_state_t;

	// counter parked saturated so nothing is captured before the first frame
	localparam rx_state_t RX_RESET = '{cnt: '1, default: '0};
	localparam logic [COUNT_W-1:0] WIDTH_C = COUNT_W'(WIDTH);

	rx_state_t          r;
	rx_state_t          n;
	logic               frame_edge;
	logic [COUNT_W-1:0] pos;
	logic [COUNT_W-1:0] start;
	logic [COUNT_W-1:0] slot_off;

	always_comb begin
		n = r;
		n.cfg_s1 = i_cfg;
		n.cfg_s2 = r.cfg_s1;
		n.fs_prev = i_frame_sync;
		if (r.cfg_s2[CFG_FRAMING] == FRAMING_TDM) begin
			frame_edge = i_frame_sync & ~r.fs_prev;
		end else begin
			frame_edge = (i_frame_sync == r.cfg_s2[CFG_STYLE]) && (r.fs_prev != r.cfg_s2[CFG_STYLE]);
		end
		pos = frame_edge ? '0 : r.cnt;
		start = r.cfg_s2[CFG_FORMAT] ? '0 : COUNT_W'(1);
		slot_off = COUNT_W'(r.cfg_s2[CFG_INDEX_LSB +: INDEX_W] * slot_clocks(r.cfg_s2[CFG_SLOT_LSB +: CODE3_W]));
		if (r.cfg_s2[CFG_FRAMING] == FRAMING_TDM) begin
			start = start + slot_off;
		end
		if (pos >= start && pos < start + WIDTH_C) begin
			n.shift = {r.shift[WIDTH-2:0], i_serial_audio_in};
			if (pos == start + WIDTH_C - COUNT_W'(1)) begin
				n.word = {r.shift[WIDTH-2:0], i_serial_audio_in};
				n.toggle = ~r.toggle;
			end
		end
		// count runs between edges and parks at all ones, so any frame long enough to hold the slot works
		if (frame_edge) begin
			n.cnt = COUNT_W'(1);
		end else if (~&r.cnt) begin
			n.cnt = r.cnt + COUNT_W'(1);
		end
	end

	always_ff @(posedge i_clk_link or posedge i_rst) begin
		if (i_rst) begin
			r <= RX_RESET;
		end else begin
			r <= n;
		end
	end

	assign o_word = r.word;
	assign o_word_toggle = r.toggle;
endmodule

// ==== hdl/dac_gain_stage.sv ====
/*
 Digital gain: 0.375 dB per code, taken as one sixteenth of an octave.
 Assumes a signed input word and a gain code stable for the valid cycle.
*/
`timescale 1ns/10ps
module dac_gain_stage #(
	parameter int unsigned WIDTH = dac_cfg_pkg::WORD_BITS
) (
	input  wire logic             i_clk_sys,
	input  wire logic             i_rst,
	input  wire logic [WIDTH-1:0] i_sample,
	input  wire logic             i_valid,
	input  wire logic [7:0]       i_gain_code,
	output logic      [WIDTH-1:0] o_sample,
	output logic                  o_valid
);
	import dac_cfg_pkg::*;

	if (WIDTH < 2) begin : g_bad_width
		$error("dac_gain_stage: width too small");
	end

	typedef struct packed {
		logic [WIDTH-1:0] sample;
		logic             valid;
	} gain_state_t;

	localparam int unsigned WIDE = WIDTH + 21;

	// 2^(-k/16) in Q15; gives 0.3763 dB per step, within 0.002 dB of nominal
	function automatic logic [15:0] frac(input logic [3:0] k);
		case (k)
			4'h0: frac = 16'h8000;
			4'h1: frac = 16'h7a93;
			4'h2: frac = 16'h7560;
			4'h3: frac = 16'h7066;
			4'h4: frac = 16'h6ba2;
			4'h5: frac = 16'h6712;
			4'h6: frac = 16'h62b4;
			4'h7: frac = 16'h5e84;
			4'h8: frac = 16'h5a82;
			4'h9: frac = 16'h56ac;
			4'ha: frac = 16'h52ff;
			4'hb: frac = 16'h4f7b;
			4'hc: frac = 16'h4c1c;
			4'hd: frac = 16'h48e2;
			4'he: frac = 16'h45cb;
			default: frac = 16'h42d5;
		endcase
	endfunction

	gain_state_t              r;
	gain_state_t              n;
	logic signed [WIDE-1:0]   wide;
	logic signed [WIDE-1:0]   hi;
	logic signed [WIDE-1:0]   lo;

	always_comb begin
		n = r;
		n.valid = i_valid;
		hi = WIDE'(signed'({1'b0, {(WIDTH-1){1'b1}}}));
		lo = -hi - WIDE'(1);
		// +24 dB headroom is four octaves above the code's own shift
		wide = WIDE'(signed'(i_sample)) * WIDE'(signed'({1'b0, frac(i_gain_code[3:0])}));
		// no truncation after the shift, so unity code passes every bit
		wide = (wide <<< HEADROOM_OCT) >>> (FRAC_BITS + 32'(i_gain_code[7:4]));
		if (i_valid) begin
			if (wide > hi) begin
				n.sample = hi[WIDTH-1:0];
			end else if (wide < lo) begin
				n.sample = lo[WIDTH-1:0];
			end else begin
				n.sample = wide[WIDTH-1:0];
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign o_sample = r.sample;
	assign o_valid = r.valid;

	AST_UNITY_GAIN: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_valid && i_gain_code == GAIN_UNITY |=> o_valid && o_sample == $past(i_sample))
		else $error("unity gain code did not pass the sample unchanged");
endmodule

// ==== hdl/dac_port_top.sv ====
/*
 Serial audio port and converter path of a mono amplifier: three control
 registers, link receiver on the host bit clock, highpass, polarity, mute
 and digital gain with soft ramping.
 Assumes the register port is driven by a control slave on the system
 clock, and the host bit clock stops only between frames.
*/
`timescale 1ns/10ps
module dac_port_top #(
	parameter int unsigned WIDTH   = dac_cfg_pkg::WORD_BITS,
	parameter int unsigned COUNT_W = 11
) (
	input  wire logic                                i_clk_sys,
	input  wire logic                                i_rst,
	input  wire logic                                i_bit_clk,
	input  wire logic                                i_frame_sync,
	input  wire logic                                i_serial_audio_in,
	input  wire logic [dac_cfg_pkg::INDEX_W-1:0]     i_slot_index,
	input  wire logic [7:0]                          i_reg_addr,
	input  wire logic                                i_reg_write,
	input  wire logic [7:0]                          i_reg_wdata,
	output logic      [7:0]                          o_reg_rdata,
	output logic      [WIDTH-1:0]                    o_sample,
	output logic                                     o_sample_valid,
	output logic                                     o_converter_low_power,
	output logic      [dac_cfg_pkg::CODE3_W-1:0]     o_sample_rate_range
);
	import dac_cfg_pkg::*;

	if (WIDTH < 8 || WIDTH > 32) begin : g_bad_width
		$error("dac_port_top: word width out of range");
	end

	typedef struct packed {
		logic [7:0]         dac_ctrl;
		logic [7:0]         volume;
		logic [7:0]         port_ctrl;
		logic [7:0]         rdata;
		logic               tog_s1;
		logic               tog_s2;
		logic               tog_s3;
		logic [WIDTH-1:0]   cap;
		logic               cap_valid;
		logic [WIDTH-1:0]   hpf_x1;
		logic [WIDTH-1:0]   hpf_y1;
		logic [WIDTH-1:0]   post;
		logic               post_valid;
		logic [7:0]         cur_gain;
	} top_state_t;

	localparam top_state_t TOP_RESET = '{
		dac_ctrl:  DAC_PATH_CONTROL_RESET,
		volume:    DIGITAL_VOLUME_RESET,
		port_ctrl: SERIAL_PORT_CONTROL_ONE_RESET,
		cur_gain:  GAIN_UNITY,
		default:   '0
	};

	localparam int unsigned HW = WIDTH + 2;

	top_state_t             r;
	top_state_t             n;
	logic                   link_clk;
	logic [CFG_BITS-1:0]    cfg;
	logic [WIDTH-1:0]       rx_word;
	logic                   rx_toggle;
	logic                   muted;
	logic signed [HW-1:0]   hpf_y;
	logic [WIDTH-1:0]       stage;
	logic [WIDTH-1:0]       hpf_sat;

	function automatic logic [WIDTH-1:0] sat(input logic signed [HW-1:0] v);
		logic signed [HW-1:0] hi;
		logic signed [HW-1:0] lo;
		hi = HW'(signed'({1'b0, {(WIDTH-1){1'b1}}}));
		lo = -hi - HW'(1);
		if (v > hi) begin
			sat = hi[WIDTH-1:0];
		end else if (v < lo) begin
			sat = lo[WIDTH-1:0];
		end else begin
			sat = v[WIDTH-1:0];
		end
	endfunction

	function automatic logic [WIDTH-1:0] neg_sat(input logic [WIDTH-1:0] v);
		neg_sat = sat(-HW'(signed'(v)));
	endfunction

	// edge choice inverts the link clock; change it only while the link is idle
	assign link_clk = i_bit_clk ^ r.port_ctrl[EDGE_BIT];

	assign cfg = {
		i_slot_index,
		r.port_ctrl[SLOT_LSB +: CODE3_W],
		r.port_ctrl[FRAMING_BIT],
		r.port_ctrl[FORMAT_BIT],
		r.port_ctrl[STYLE_BIT]
	};

	dac_serial_rx #(
		.WIDTH   (WIDTH),
		.COUNT_W (COUNT_W)
	) u_rx (
		.i_clk_link        (link_clk),
		.i_rst             (i_rst),
		.i_frame_sync      (i_frame_sync),
		.i_serial_audio_in (i_serial_audio_in),
		.i_cfg             (cfg),
		.o_word            (rx_word),
		.o_word_toggle     (rx_toggle)
	);

	assign muted = r.dac_ctrl[MUTE_BIT] || r.volume == GAIN_MUTE;

	always_comb begin
		n = r;
		n.cap_valid = 1'b0;
		n.post_valid = 1'b0;

		if (i_reg_write) begin
			if (i_reg_addr == DAC_PATH_CONTROL_ADDR) begin
				n.dac_ctrl = i_reg_wdata;
			end else if (i_reg_addr == DIGITAL_VOLUME_ADDR) begin
				n.volume = i_reg_wdata;
			end else if (i_reg_addr == SERIAL_PORT_CONTROL_ONE_ADDR) begin
				n.port_ctrl = i_reg_wdata;
			end
		end
		if (i_reg_addr == DAC_PATH_CONTROL_ADDR) begin
			n.rdata = r.dac_ctrl;
		end else if (i_reg_addr == DIGITAL_VOLUME_ADDR) begin
			n.rdata = r.volume;
		end else if (i_reg_addr == SERIAL_PORT_CONTROL_ONE_ADDR) begin
			n.rdata = r.port_ctrl;
		end else begin
			n.rdata = UNMAPPED_READ;
		end

		// word is stable on the link side long before its toggle arrives here
		n.tog_s1 = rx_toggle;
		n.tog_s2 = r.tog_s1;
		n.tog_s3 = r.tog_s2;
		if (r.tog_s3 != r.tog_s2) begin
			n.cap = rx_word;
			n.cap_valid = 1'b1;
		end

		// dc blocker: y = x - x1 + y1 - y1/2^k
		hpf_y = HW'(signed'(r.cap)) - HW'(signed'(r.hpf_x1)) + HW'(signed'(r.hpf_y1))
			- (HW'(signed'(r.hpf_y1)) >>> HPF_SHIFT);
		hpf_sat = sat(hpf_y);
		stage = r.cap;
		if (r.cap_valid) begin
			n.hpf_x1 = r.cap;
			if (r.dac_ctrl[HIGHPASS_BIT]) begin
				n.hpf_y1 = hpf_sat;
				stage = hpf_sat;
			end else begin
				// input tracked and feedback cleared so switching the filter on does not click
				n.hpf_y1 = '0;
			end
			if (r.port_ctrl[INVERT_BIT]) begin
				stage = neg_sat(stage);
			end
			n.post = muted ? '0 : stage;
			n.post_valid = 1'b1;
		end

		if (r.dac_ctrl[HARD_VOLUME_BIT]) begin
			n.cur_gain = r.volume;
		end else if (r.post_valid && r.cur_gain < r.volume) begin
			n.cur_gain = r.cur_gain + GAIN_STEP;
		end else if (r.post_valid && r.cur_gain > r.volume) begin
			n.cur_gain = r.cur_gain - GAIN_STEP;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			r <= TOP_RESET;
		end else begin
			r <= n;
		end
	end

	dac_gain_stage #(
		.WIDTH (WIDTH)
	) u_gain (
		.i_clk_sys   (i_clk_sys),
		.i_rst       (i_rst),
		.i_sample    (r.post),
		.i_valid     (r.post_valid),
		.i_gain_code (r.cur_gain),
		.o_sample    (o_sample),
		.o_valid     (o_sample_valid)
	);

	assign o_reg_rdata = r.rdata;
	assign o_converter_low_power = r.dac_ctrl[LOW_POWER_BIT];
	assign o_sample_rate_range = r.dac_ctrl[RATE_LSB +: CODE3_W];

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);

	sequence s_dac_write;
		i_reg_write && i_reg_addr == DAC_PATH_CONTROL_ADDR;
	endsequence

	sequence s_vol_write_hard;
		i_reg_write && i_reg_addr == DIGITAL_VOLUME_ADDR && r.dac_ctrl[HARD_VOLUME_BIT]
			&& !(i_reg_write && i_reg_addr == DAC_PATH_CONTROL_ADDR);
	endsequence

	sequence s_word_arrives;
		r.tog_s3 != r.tog_s2;
	endsequence

	sequence s_vol_write;
		i_reg_write && i_reg_addr == DIGITAL_VOLUME_ADDR;
	endsequence

	sequence s_port_write;
		i_reg_write && i_reg_addr == SERIAL_PORT_CONTROL_ONE_ADDR;
	endsequence

	AST_LOW_POWER_FOLLOWS: assert property (
		s_dac_write |=> o_converter_low_power == $past(i_reg_wdata[LOW_POWER_BIT]))
		else $error("low power output did not follow the written bit");

	AST_RATE_FOLLOWS: assert property (
		s_dac_write |=> o_sample_rate_range == $past(i_reg_wdata[RATE_LSB +: CODE3_W]))
		else $error("rate range output did not follow the written field");

	AST_WORD_TO_OUTPUT: assert property (
		s_word_arrives |=> r.cap_valid ##1 r.post_valid ##1 o_sample_valid)
		else $error("received word did not reach the output in three cycles");

	AST_HPF_BYPASS: assert property (
		r.cap_valid && !r.dac_ctrl[HIGHPASS_BIT] && !r.port_ctrl[INVERT_BIT] && !muted
		|=> r.post == $past(r.cap))
		else $error("bypassed filter altered the sample");

	AST_MUTE_SILENCE: assert property (
		r.cap_valid && muted |=> r.post_valid && r.post == '0)
		else $error("muted path passed a nonzero sample");

	AST_INVERT_SIGN: assert property (
		r.cap_valid && r.port_ctrl[INVERT_BIT] && !r.dac_ctrl[HIGHPASS_BIT] && !muted
		&& r.cap != {1'b1, {(WIDTH-1){1'b0}}}
		|=> r.post == WIDTH'(-$past(r.cap)))
		else $error("inverted output is not the negated sample");

	AST_HARD_VOLUME: assert property (
		s_vol_write_hard ##1 r.dac_ctrl[HARD_VOLUME_BIT] |=> r.cur_gain == $past(i_reg_wdata, 2))
		else $error("hard volume did not take effect two cycles after the write");

	AST_SOFT_STEP: assert property (
		!r.dac_ctrl[HARD_VOLUME_BIT] && r.cur_gain != r.volume && !r.post_valid |=> $stable(r.cur_gain))
		else $error("soft ramp moved without a sample");

	AST_SOFT_ONE_CODE: assert property (
		!r.dac_ctrl[HARD_VOLUME_BIT] && r.post_valid && r.cur_gain < r.volume
		|=> r.cur_gain == $past(r.cur_gain) + GAIN_STEP)
		else $error("soft ramp did not step by one code");

	AST_SOFT_ONE_CODE_DOWN: assert property (
		!r.dac_ctrl[HARD_VOLUME_BIT] && r.post_valid && r.cur_gain > r.volume
		|=> r.cur_gain == $past(r.cur_gain) - GAIN_STEP)
		else $error("soft ramp did not step down by one code");

	// readback trails the address by one cycle
	AST_DAC_READBACK: assert property (
		s_dac_write ##1 $stable(i_reg_addr) |=> o_reg_rdata == $past(i_reg_wdata, 2))
		else $error("control register did not read back the written value");

	AST_VOLUME_READBACK: assert property (
		s_vol_write ##1 $stable(i_reg_addr) |=> o_reg_rdata == $past(i_reg_wdata, 2))
		else $error("volume register did not read back the written value");

	AST_PORT_READBACK: assert property (
		s_port_write ##1 $stable(i_reg_addr) |=> o_reg_rdata == $past(i_reg_wdata, 2))
		else $error("port register did not read back the written value");

	AST_HARD_TRACKS: assert property (
		r.dac_ctrl[HARD_VOLUME_BIT] |=> r.cur_gain == $past(r.volume))
		else $error("hard volume gain did not follow the register");

	// a repeated level with clear feedback must cancel completely
	AST_HPF_BLOCKS_DC: assert property (
		r.cap_valid && r.dac_ctrl[HIGHPASS_BIT] && !r.port_ctrl[INVERT_BIT] && !muted
		&& r.cap == r.hpf_x1 && r.hpf_y1 == '0
		|=> r.post == '0)
		else $error("enabled filter passed a constant level");

	AST_SILENT_OUTPUT: assert property (
		r.post_valid && r.post == '0 |=> o_sample_valid && o_sample == '0)
		else $error("a silent sample left the gain stage nonzero");

	AST_CAPTURE_PULSE: assert property (
		r.cap_valid |=> !r.cap_valid)
		else $error("one received word was captured twice");
endmodule

// ==== testbench/host_audio_source.sv ====
/*
 Host audio source: drives bit clock, frame sync and serial data of the link.
 Assumes the bench calls send_frame with the settings it has just programmed.
*/
`timescale 1ns/10ps
module host_audio_source (
	output logic o_bit_clk,
	output logic o_frame_sync,
	output logic o_serial_audio_in
);
	initial begin
		o_bit_clk = 1'b0;
		o_frame_sync = 1'b0;
		o_serial_audio_in = 1'b0;
	end

	// clock stands still between frames; unused data toggles so a stale bit never looks valid
	task automatic send_frame(input logic [23:0] word, input logic tdm, input logic high_left,
		input logic no_delay, input logic fall, input int offset, input int len);
		int p;
		int k;
		logic idle;
		idle = fall;
		o_bit_clk = idle;
		for (p = -4; p < len; p++) begin
			if (tdm) begin
				o_frame_sync = high_left ? (p >= 0 && p < len / 2) : (p == 0);
			end else begin
				o_frame_sync = (p >= 0 && p < len / 2) ~^ high_left;
			end
			k = p - offset - (no_delay ? 0 : 1);
			if (k >= 0 && k < 24) begin
				o_serial_audio_in = word[23 - k];
			end else begin
				o_serial_audio_in = ~o_serial_audio_in;
			end
			#3 o_bit_clk = ~idle;
			#3 o_bit_clk = idle;
		end
		o_serial_audio_in = ~o_serial_audio_in;
	endtask
endmodule

// ==== testbench/test_serial_audio_dac_config.sv ====
/*
 Self-checking bench for the serial audio port and converter path.
 Assumes host_audio_source as the far side and a 50 MHz system clock.
*/
`timescale 1ns/10ps
module test_serial_audio_dac_config;
	import dac_cfg_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        bit_clk;
	logic        frame_sync;
	logic        serial_audio_in;
	logic [3:0]  slot_index = 4'h0;
	logic [7:0]  reg_addr = 8'h00;
	logic        reg_write = 1'b0;
	logic [7:0]  reg_wdata = 8'h00;
	logic [7:0]  reg_rdata;
	logic [23:0] sample;
	logic        sample_valid;
	logic        low_power;
	logic [2:0]  rate_range;
	logic [23:0] got;
	int          num_errors = 0;
	int          n_checks = 0;

	always #10 clk_sys = ~clk_sys;

	host_audio_source i_host_audio_source (
		.o_bit_clk         (bit_clk),
		.o_frame_sync      (frame_sync),
		.o_serial_audio_in (serial_audio_in)
	);

	dac_port_top i_dac_port_top (
		.i_clk_sys             (clk_sys),
		.i_rst                 (rst),
		.i_bit_clk             (bit_clk),
		.i_frame_sync          (frame_sync),
		.i_serial_audio_in     (serial_audio_in),
		.i_slot_index          (slot_index),
		.i_reg_addr            (reg_addr),
		.i_reg_write           (reg_write),
		.i_reg_wdata           (reg_wdata),
		.o_reg_rdata           (reg_rdata),
		.o_sample              (sample),
		.o_sample_valid        (sample_valid),
		.o_converter_low_power (low_power),
		.o_sample_rate_range   (rate_range)
	);

	task automatic results();
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic check(input logic [23:0] act, input logic [23:0] exp);
		n_checks++;
		if (act !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, act, exp);
		end
	endtask

	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(negedge clk_sys);
		reg_addr = addr;
		reg_wdata = data;
		reg_write = 1'b1;
		@(negedge clk_sys);
		reg_write = 1'b0;
	endtask

	task automatic read_check(input logic [7:0] addr, input logic [7:0] exp);
		@(negedge clk_sys);
		reg_addr = addr;
		@(negedge clk_sys);
		check(24'(reg_rdata), 24'(exp));
	endtask

	// programs the port, sends one frame and waits for the converted sample
	task automatic stream(input logic [23:0] word, input logic [7:0] port, input int offset, input int len);
		int n;
		write_reg(SERIAL_PORT_CONTROL_ONE_ADDR, port);
		fork
			i_host_audio_source.send_frame(word, port[FRAMING_BIT], port[STYLE_BIT], port[FORMAT_BIT],
				port[EDGE_BIT], offset, len);
			begin
				n = 0;
				while (sample_valid !== 1'b1 && n < 400) begin
					@(negedge clk_sys);
					n++;
				end
				if (n == 400) begin
					num_errors++;
					results();
				end
				got = sample;
			end
		join
	endtask

	task automatic path_case(input logic [7:0] path, input logic [7:0] digital_gain_code, input logic [23:0] w,
		input logic [7:0] port);
		write_reg(DAC_PATH_CONTROL_ADDR, path);
		write_reg(DIGITAL_VOLUME_ADDR, digital_gain_code);
		stream(w, port, 0, 64);
	endtask

	task automatic reset_values();
		read_check(DAC_PATH_CONTROL_ADDR, 8'h32);
		read_check(DIGITAL_VOLUME_ADDR, 8'h40);
		read_check(SERIAL_PORT_CONTROL_ONE_ADDR, 8'h11);
		check(24'(low_power), 24'h1);
		check(24'(rate_range), 24'h2);
		write_reg(8'h07, 8'h5a);
		read_check(8'h07, 8'h00);
		write_reg(DIGITAL_VOLUME_ADDR, 8'ha5);
		read_check(DIGITAL_VOLUME_ADDR, 8'ha5);
		read_check(DAC_PATH_CONTROL_ADDR, 8'h32);
	endtask

	task automatic rate_and_power();
		for (int c = 0; c < 6; c++) begin
			write_reg(DAC_PATH_CONTROL_ADDR, {5'h10, 3'(c)});
			@(negedge clk_sys);
			check(24'(rate_range), 24'(c));
			check(24'(low_power), 24'h0);
		end
	endtask

	task automatic formats();
		logic [7:0] port;
		logic [23:0] w;
		write_reg(DAC_PATH_CONTROL_ADDR, 8'h80);
		write_reg(DIGITAL_VOLUME_ADDR, 8'h40);
		for (int i = 0; i < 16; i++) begin
			port = {1'b0, 1'(i >> 3), 3'h2, 3'(i)};
			w = 24'h5a3c00 ^ 24'(i * 17);
			stream(w, port, 0, port[0] ? 128 : 64);
			check(got, w);
		end
	endtask

	task automatic slots();
		int clocks[5] = '{16, 24, 32, 48, 64};
		slot_index = 4'h1;
		for (int c = 0; c < 5; c++) begin
			stream(24'h123450 + 24'(c), {2'b00, 3'(c), 3'b011}, clocks[c], 128);
			check(got, 24'h123450 + 24'(c));
		end
		slot_index = 4'h0;
	endtask

	task automatic frame_lengths();
		stream(24'h7f0001, 8'h10, 0, 52);
		check(got, 24'h7f0001);
		stream(24'h00ff80, 8'h13, 0, 300);
		check(got, 24'h00ff80);
	endtask

	task automatic output_path();
		path_case(8'hc0, 8'h40, 24'h123456, 8'h12);
		check(got, 24'h000000);
		path_case(8'h80, 8'hff, 24'h123456, 8'h12);
		check(got, 24'h000000);
		path_case(8'h80, 8'h40, 24'h123456, 8'h92);
		check(got, 24'hedcbaa);
		path_case(8'h80, 8'h00, 24'h000100, 8'h12);
		check(got, 24'h001000);
		path_case(8'h80, 8'h50, 24'h000400, 8'h12);
		check(got, 24'h000200);
		path_case(8'h80, 8'hfe, 24'h400000, 8'h12);
		check(24'(got != 24'h0 && got < 24'h000800), 24'h1);
		// soft ramp starts from code fe left by the previous case, so one step cannot reach unity
		path_case(8'h00, 8'h40, 24'h100000, 8'h12);
		check(24'(got < 24'h001000), 24'h1);
		path_case(8'ha0, 8'h40, 24'h100000, 8'h12);
		repeat (2) stream(24'h100000, 8'h12, 0, 64);
		check(24'(got !== 24'h100000), 24'h1);
	endtask

	initial begin
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'b0;
		reset_values();
		rate_and_power();
		formats();
		slots();
		frame_lengths();
		output_path();
		results();
	end
endmodule
